// *** rtl/bit_branch_pkg.sv ***
// Package for the carry bit unit and branch condition evaluator.
// Assumes a single core clock and synchronous active-low reset.
package bit_branch_pkg;

   // Width of the byte operand and of the bit position field.
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned POS_W  = 3;

   // Carry bit operations, one-hot.
   typedef enum logic [10:0] {
      OP_NONE                        = 11'h001,
      OP_CARRY_AND_BIT               = 11'h002,
      OP_CARRY_AND_INVERTED_BIT      = 11'h004,
      OP_CARRY_OR_BIT                = 11'h008,
      OP_CARRY_OR_INVERTED_BIT       = 11'h010,
      OP_CARRY_XOR_BIT               = 11'h020,
      OP_CARRY_XOR_INVERTED_BIT      = 11'h040,
      OP_LOAD_BIT_TO_CARRY           = 11'h080,
      OP_LOAD_INVERTED_BIT_TO_CARRY  = 11'h100,
      OP_STORE_CARRY_TO_BIT          = 11'h200,
      OP_STORE_INVERTED_CARRY_TO_BIT = 11'h400
   } bit_op_t;

   // Branch conditions, plain binary encoding from the instruction field.
   typedef enum logic [3:0] {
      COND_JUMP_UNCONDITIONAL     = 4'h0,
      COND_JUMP_NEVER             = 4'h1,
      COND_JUMP_IF_ABOVE          = 4'h2,
      COND_JUMP_IF_BELOW_OR_SAME  = 4'h3,
      COND_JUMP_ON_CARRY_CLEAR    = 4'h4,
      COND_JUMP_ON_CARRY_SET      = 4'h5,
      COND_JUMP_IF_NOT_EQUAL      = 4'h6,
      COND_JUMP_IF_EQUAL          = 4'h7,
      COND_JUMP_ON_OVERFLOW_CLEAR = 4'h8
   } cond_t;

   // Reset values.
   localparam logic             CARRY_RST = 1'b0;
   localparam logic             FLAG_RST  = 1'b0;
   localparam logic             PULSE_RST = 1'b0;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [31:0]       ADDR_RST = 32'h0000_0000;

   // Address step to the next sequential instruction.
   localparam logic [31:0] INSN_STEP = 32'h0000_0002;

endpackage : bit_branch_pkg

// *** rtl/bit_carry_branch.sv ***
// Carry bit unit and conditional branch evaluator of the core datapath.
// Assumes operands and flags are stable and synchronous when the strobes rise.
// Functional notes
// - Carry-AND: carry becomes carry AND the selected bit.
// - Carry-OR: carry becomes carry OR the selected bit.
// - Carry-XOR: carry becomes carry XOR the selected bit.
// - Inverted carry-AND: carry becomes carry AND NOT selected bit.
// - Inverted carry-OR: carry becomes carry OR NOT selected bit.
// - Inverted carry-XOR: carry becomes carry XOR NOT selected bit.
// - Bit load: selected bit replaces the carry.
// - Inverted bit load: complement of selected bit replaces the carry.
// - Bit store: carry written into selected bit, other seven bits kept.
// - Inverted bit store: complement of carry written into selected bit.
// - Inverted variants take the bit position from a 3-bit immediate.
// - Branch goes to target only when condition true, else next instruction.
// - Above and below-or-same use carry and zero; carry clear and carry set use carry only.
// - Always, never, not-equal, equal and overflow-clear evaluate as named.
`timescale 1ns/1ps
`default_nettype none
module bit_carry_branch (
   // Clock and reset.
   input  wire logic                                 clk,
   input  wire logic                                 nrst,
   // Bit operation request.
   input  wire logic                                 bit_op_valid,
   input  wire bit_branch_pkg::bit_op_t              bit_op,
   input  wire logic [bit_branch_pkg::BYTE_W-1:0]    operand_byte,
   input  wire logic [bit_branch_pkg::POS_W-1:0]     imm_bit_pos,
   input  wire logic [bit_branch_pkg::POS_W-1:0]     reg_bit_pos,
   input  wire logic                                 pos_from_reg,
   // Condition flags in.
   input  wire logic                                 carry_in,
   input  wire logic                                 zero_in,
   input  wire logic                                 overflow_in,
   input  wire logic                                 negative_in,
   // Branch request.
   input  wire logic                                 branch_valid,
   input  wire bit_branch_pkg::cond_t                branch_cond,
   input  wire logic [31:0]                          branch_target,
   input  wire logic [31:0]                          insn_addr,
   // Flag results.
   output logic                                      carry_out,
   output logic                                      zero_out,
   output logic                                      overflow_out,
   output logic                                      negative_out,
   output logic                                      flags_valid,
   // Byte write-back.
   output logic [bit_branch_pkg::BYTE_W-1:0]         result_byte,
   output logic                                      result_byte_we,
   // Branch result.
   output logic                                      branch_taken,
   output logic [31:0]                               next_addr,
   output logic                                      branch_done
);

   // All state of the block.
   typedef struct packed {
      logic                              carry;
      logic                              zero;
      logic                              overflow;
      logic                              negative;
      logic                              flags_valid;
      logic [bit_branch_pkg::BYTE_W-1:0] byte_val;
      logic                              byte_we;
      logic                              taken;
      logic [31:0]                       addr;
      logic                              done;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Evaluates a branch condition from the flags.
   function automatic logic cond_true(bit_branch_pkg::cond_t cond, logic c, logic z, logic v);
      logic r;
      r = 1'b0;
      unique case (cond)
         bit_branch_pkg::COND_JUMP_UNCONDITIONAL:     r = 1'b1;
         bit_branch_pkg::COND_JUMP_NEVER:             r = 1'b0;
         bit_branch_pkg::COND_JUMP_IF_ABOVE:          r = ~(c | z);
         bit_branch_pkg::COND_JUMP_IF_BELOW_OR_SAME:  r = c | z;
         bit_branch_pkg::COND_JUMP_ON_CARRY_CLEAR:    r = ~c;
         bit_branch_pkg::COND_JUMP_ON_CARRY_SET:      r = c;
         bit_branch_pkg::COND_JUMP_IF_NOT_EQUAL:      r = ~z;
         bit_branch_pkg::COND_JUMP_IF_EQUAL:          r = z;
         bit_branch_pkg::COND_JUMP_ON_OVERFLOW_CLEAR: r = ~v;
         default:                                     r = 1'b0;
      endcase
      return r;
   endfunction : cond_true

   // True for the inverted forms, which may only name their bit by immediate.
   function automatic logic is_inverted_op(bit_branch_pkg::bit_op_t op);
      logic r;
      r = 1'b0;
      unique case (op)
         bit_branch_pkg::OP_CARRY_AND_INVERTED_BIT,
         bit_branch_pkg::OP_CARRY_OR_INVERTED_BIT,
         bit_branch_pkg::OP_CARRY_XOR_INVERTED_BIT,
         bit_branch_pkg::OP_LOAD_INVERTED_BIT_TO_CARRY,
         bit_branch_pkg::OP_STORE_INVERTED_CARRY_TO_BIT: r = 1'b1;
         default:                                        r = 1'b0;
      endcase
      return r;
   endfunction : is_inverted_op

   // True for the two store forms, the only ones that write the byte back.
   function automatic logic is_store_op(bit_branch_pkg::bit_op_t op);
      return (op == bit_branch_pkg::OP_STORE_CARRY_TO_BIT) ||
             (op == bit_branch_pkg::OP_STORE_INVERTED_CARRY_TO_BIT);
   endfunction : is_store_op

   // Picks the bit position; inverted forms ignore a position held in a register.
   function automatic logic [bit_branch_pkg::POS_W-1:0] bit_position(
      bit_branch_pkg::bit_op_t          op,
      logic                             from_reg,
      logic [bit_branch_pkg::POS_W-1:0] reg_pos,
      logic [bit_branch_pkg::POS_W-1:0] imm_pos);
      return (from_reg && !is_inverted_op(op)) ? reg_pos : imm_pos;
   endfunction : bit_position

   // New carry after a bit operation; store forms and idle codes keep the carry.
   function automatic logic carry_after(bit_branch_pkg::bit_op_t op, logic c, logic sel);
      logic r;
      r = c;
      unique case (op)
         bit_branch_pkg::OP_CARRY_AND_BIT:               r = c & sel;
         bit_branch_pkg::OP_CARRY_AND_INVERTED_BIT:      r = c & ~sel;
         bit_branch_pkg::OP_CARRY_OR_BIT:                r = c | sel;
         bit_branch_pkg::OP_CARRY_OR_INVERTED_BIT:       r = c | ~sel;
         bit_branch_pkg::OP_CARRY_XOR_BIT:               r = c ^ sel;
         bit_branch_pkg::OP_CARRY_XOR_INVERTED_BIT:      r = c ^ ~sel;
         bit_branch_pkg::OP_LOAD_BIT_TO_CARRY:           r = sel;
         bit_branch_pkg::OP_LOAD_INVERTED_BIT_TO_CARRY:  r = ~sel;
         default:                                        r = c;
      endcase
      return r;
   endfunction : carry_after

   // Byte after a bit operation: a store changes the selected bit and no other.
   function automatic logic [bit_branch_pkg::BYTE_W-1:0] byte_after(
      bit_branch_pkg::bit_op_t           op,
      logic [bit_branch_pkg::BYTE_W-1:0] b,
      logic [bit_branch_pkg::POS_W-1:0]  pos,
      logic                              c);
      logic [bit_branch_pkg::BYTE_W-1:0] r;
      r = b;
      if (op == bit_branch_pkg::OP_STORE_CARRY_TO_BIT) begin
         r[pos] = c;
      end else if (op == bit_branch_pkg::OP_STORE_INVERTED_CARRY_TO_BIT) begin
         r[pos] = ~c;
      end
      return r;
   endfunction : byte_after

   // Computes the next state from the requests.
   always_comb begin
      logic [bit_branch_pkg::POS_W-1:0]  pos;
      logic                              sel;
      logic                              c;
      pos    = '0;
      sel    = 1'b0;
      c      = carry_in;
      state_next          = state_reg;
      state_next.byte_we  = 1'b0;
      state_next.done     = 1'b0;
      state_next.flags_valid = 1'b0;
      // Inverted forms only accept an immediate bit position.
      pos = bit_position(bit_op, pos_from_reg, reg_bit_pos, imm_bit_pos);
      sel = operand_byte[pos];
      c   = carry_after(bit_op, carry_in, sel);
      if (bit_op_valid) begin
         // Only the carry may change; other flags pass through.
         state_next.carry       = c;
         state_next.zero        = zero_in;
         state_next.overflow    = overflow_in;
         state_next.negative    = negative_in;
         state_next.flags_valid = 1'b1;
         // Stores write the byte back; every other form returns the operand unchanged.
         state_next.byte_val    = byte_after(bit_op, operand_byte, pos, carry_in);
         state_next.byte_we     = is_store_op(bit_op);
      end else if (branch_valid) begin
         // Branch evaluation leaves every flag as it was.
         state_next.carry       = carry_in;
         state_next.zero        = zero_in;
         state_next.overflow    = overflow_in;
         state_next.negative    = negative_in;
      end
      // Branch selects target or the next sequential instruction.
      if (branch_valid) begin
         state_next.taken = cond_true(branch_cond, carry_in, zero_in, overflow_in);
         state_next.addr  = state_next.taken ? branch_target
                                             : insn_addr + bit_branch_pkg::INSN_STEP;
         state_next.done  = 1'b1;
      end
   end

   // Registers the state.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= '{carry:       bit_branch_pkg::CARRY_RST,
                        zero:        bit_branch_pkg::FLAG_RST,
                        overflow:    bit_branch_pkg::FLAG_RST,
                        negative:    bit_branch_pkg::FLAG_RST,
                        flags_valid: bit_branch_pkg::PULSE_RST,
                        byte_val:    bit_branch_pkg::BYTE_RST,
                        byte_we:     bit_branch_pkg::PULSE_RST,
                        taken:       bit_branch_pkg::FLAG_RST,
                        addr:        bit_branch_pkg::ADDR_RST,
                        done:        bit_branch_pkg::PULSE_RST};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from the state register.
   assign carry_out      = state_reg.carry;
   assign zero_out       = state_reg.zero;
   assign overflow_out   = state_reg.overflow;
   assign negative_out   = state_reg.negative;
   assign flags_valid    = state_reg.flags_valid;
   assign result_byte    = state_reg.byte_val;
   assign result_byte_we = state_reg.byte_we;
   assign branch_taken   = state_reg.taken;
   assign next_addr      = state_reg.addr;
   assign branch_done    = state_reg.done;

endmodule : bit_carry_branch
`default_nettype wire

// *** verification/bit_carry_branch_chk.sv ***
// Assertions for the carry bit unit and branch evaluator.
// Sees only the block's ports; bound to the block below the module.
`timescale 1ns/1ps
`default_nettype none
module bit_carry_branch_chk (
   // Clock and reset.
   input wire logic                    clk,
   input wire logic                    nrst,
   // Bit operation request.
   input wire logic                    bit_op_valid,
   input wire bit_branch_pkg::bit_op_t bit_op,
   input wire logic [7:0]              operand_byte,
   input wire logic [2:0]              imm_bit_pos,
   input wire logic [2:0]              reg_bit_pos,
   input wire logic                    pos_from_reg,
   // Condition flags in.
   input wire logic                    carry_in,
   input wire logic                    zero_in,
   input wire logic                    overflow_in,
   input wire logic                    negative_in,
   // Branch request.
   input wire logic                    branch_valid,
   input wire bit_branch_pkg::cond_t   branch_cond,
   input wire logic [31:0]             branch_target,
   input wire logic [31:0]             insn_addr,
   // Results.
   input wire logic                    carry_out,
   input wire logic                    zero_out,
   input wire logic                    overflow_out,
   input wire logic                    negative_out,
   input wire logic [7:0]              result_byte,
   input wire logic                    result_byte_we,
   input wire logic                    branch_taken,
   input wire logic [31:0]             next_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic       sb, ib, tk;
   logic [2:0] p;
   logic [7:0] st, si;
   logic [8:0] cv;
   // Selected bits, expected store bytes and branch decision; op codes are one-hot.
   always_comb begin
      p = pos_from_reg ? reg_bit_pos : imm_bit_pos;
      sb = operand_byte[p];
      ib = operand_byte[imm_bit_pos];
      st = operand_byte;
      st[p] = carry_in;
      si = operand_byte;
      si[imm_bit_pos] = !carry_in;
      cv = {!overflow_in, zero_in, !zero_in, carry_in, !carry_in, carry_in | zero_in,
            !(carry_in | zero_in), 1'b0, 1'b1};
      tk = (branch_cond < 4'h9) && cv[branch_cond];
   end
   a_and_bit: assert property (bit_op_valid && bit_op[1] |=>
      carry_out == $past(carry_in & sb)) else $error("and bit");
   a_and_inv: assert property (bit_op_valid && bit_op[2] |=>
      carry_out == $past(carry_in & !ib)) else $error("and inverted");
   a_or_bit: assert property (bit_op_valid && bit_op[3] |=>
      carry_out == $past(carry_in | sb)) else $error("or bit");
   a_or_inv: assert property (bit_op_valid && bit_op[4] |=>
      carry_out == $past(carry_in | !ib)) else $error("or inverted");
   a_xor_bit: assert property (bit_op_valid && bit_op[5] |=>
      carry_out == $past(carry_in ^ sb)) else $error("xor bit");
   a_xor_inv: assert property (bit_op_valid && bit_op[6] |=>
      carry_out == $past(carry_in ^ !ib)) else $error("xor inverted");
   a_load_bit: assert property (bit_op_valid && bit_op[7] |=>
      carry_out == $past(sb)) else $error("load bit");
   a_load_inv: assert property (bit_op_valid && bit_op[8] |=>
      carry_out == $past(!ib)) else $error("load inverted");
   a_store_bit: assert property (bit_op_valid && bit_op[9] |=>
      result_byte_we && result_byte == $past(st) && carry_out == $past(carry_in))
      else $error("store bit");
   a_store_inv: assert property (bit_op_valid && bit_op[10] |=>
      result_byte_we && result_byte == $past(si)) else $error("store inverted");
   a_branch_pick: assert property (branch_valid |=>
      branch_taken == $past(tk) &&
      next_addr == ($past(tk) ? $past(branch_target) : $past(insn_addr) + 32'h2))
      else $error("branch decision");
   a_flags_kept: assert property ((bit_op_valid || branch_valid) |=>
      {zero_out, overflow_out, negative_out} == $past({zero_in, overflow_in, negative_in}))
      else $error("other flags changed");
   a_idle_hold: assert property (!bit_op_valid && !branch_valid |=>
      {carry_out, zero_out, overflow_out, negative_out, result_byte, branch_taken, next_addr} ==
      $past({carry_out, zero_out, overflow_out, negative_out, result_byte, branch_taken,
             next_addr}))
      else $error("outputs changed while idle");
endmodule : bit_carry_branch_chk
bind bit_carry_branch bit_carry_branch_chk chk (.clk, .nrst, .bit_op_valid, .pos_from_reg,
   .branch_valid, .carry_in, .zero_in, .overflow_in, .negative_in, .carry_out, .zero_out,
   .overflow_out, .negative_out, .result_byte_we, .branch_taken, .bit_op, .branch_cond,
   .operand_byte, .result_byte, .imm_bit_pos, .reg_bit_pos, .branch_target, .insn_addr,
   .next_addr);
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the carry bit unit and branch evaluator.
// Inputs change at the falling edge from an LFSR; results are checked via queues.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, nrst = 1'b0, bit_op_valid = 1'b0, pos_from_reg = 1'b0;
   logic branch_valid = 1'b0, carry_in = 1'b0, zero_in = 1'b0, overflow_in = 1'b0;
   logic negative_in = 1'b0, carry_out, zero_out, overflow_out, negative_out, flags_valid;
   logic result_byte_we, branch_taken, branch_done;
   logic [7:0] operand_byte = 8'h00, result_byte;
   logic [2:0] imm_bit_pos = 3'h0, reg_bit_pos = 3'h0;
   logic [31:0] branch_target = 32'h0, insn_addr = 32'h0, next_addr;
   bit_branch_pkg::bit_op_t bit_op = bit_branch_pkg::OP_NONE;
   bit_branch_pkg::cond_t   branch_cond = bit_branch_pkg::COND_JUMP_NEVER;
   logic [35:0] qb[$], qr[$];
   int          failures = 0, samples_checked = 0;
   logic [15:0] lf = 16'h7fd6;
   bit_carry_branch DUT (.clk, .nrst, .bit_op_valid, .bit_op, .operand_byte, .imm_bit_pos,
      .reg_bit_pos, .pos_from_reg, .carry_in, .zero_in, .overflow_in, .negative_in,
      .branch_valid, .branch_cond, .branch_target, .insn_addr, .carry_out, .zero_out,
      .overflow_out, .negative_out, .flags_valid, .result_byte, .result_byte_we,
      .branch_taken, .next_addr, .branch_done);
   always #12.5 clk = ~clk;
   task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Next state of the 16-bit stimulus shift register, maximal length.
   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // Each result pulse takes the oldest expectation of its kind.
   always @(negedge clk) begin
      if (flags_valid === 1'b1) check("bit op", {result_byte_we, carry_out, zero_out,
         overflow_out, negative_out, result_byte}, qb.pop_front());
      if (branch_done === 1'b1) check("branch", {branch_taken, next_addr, carry_out},
         qr.pop_front());
   end
   // A hang is cut short well past the expected run of some 450 cycles.
   initial begin
      repeat (2000) @(posedge clk);
      failures++;
      print_verdict();
   end
   // Random traffic, each code in turn, mixing bit ops, branches and idle cycles.
   initial begin
      logic [63:0] r;
      logic [8:0]  t;
      logic [7:0]  by;
      logic [2:0]  p;
      logic        c, x;
      int          k;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      for (int i = 0; i < 440; i++) begin
         @(negedge clk);
         for (int j = 0; j < 4; j++) begin
            lf = lfsr_next(lf);
            r = {r[47:0], lf};
         end
         {operand_byte, imm_bit_pos, reg_bit_pos, pos_from_reg, carry_in, zero_in,
          overflow_in, negative_in} = r[18:0];
         branch_target = r[63:32];
         insn_addr = {r[31:1], 1'b0};
         bit_op_valid = r[19] & r[20];
         branch_valid = !r[19] & r[20];
         k = i % 11;
         bit_op = bit_branch_pkg::bit_op_t'(11'h001 << k);
         branch_cond = bit_branch_pkg::cond_t'(i % 10);
         p = (pos_from_reg && (k[0] || k < 2)) ? reg_bit_pos : imm_bit_pos;
         x = k[0] ? operand_byte[p] : !operand_byte[p];
         c = carry_in;
         by = operand_byte;
         if (k == 1 || k == 2) c = c & x;
         if (k == 3 || k == 4) c = c | x;
         if (k == 5 || k == 6) c = c ^ x;
         if (k == 7 || k == 8) c = x;
         if (k > 8) by[p] = (k == 9) ? c : !c;
         if (bit_op_valid) qb.push_back(36'({k > 8, c, zero_in, overflow_in, negative_in, by}));
         t = {!overflow_in, zero_in, !zero_in, carry_in, !carry_in, carry_in | zero_in,
              !(carry_in | zero_in), 1'b0, 1'b1} >> (i % 10);
         if (branch_valid) qr.push_back(36'({t[0], t[0] ? branch_target : insn_addr + 32'h2,
            carry_in}));
      end
      @(negedge clk);
      bit_op_valid = 1'b0;
      branch_valid = 1'b0;
      repeat (3) @(negedge clk);
      check("left over", 36'(qb.size() + qr.size()), 36'h0);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
